// file: design/aux_consts.svh
// constants shared by both ends of the auxiliary converter readback
`ifndef AUX_CONSTS_SVH
`define AUX_CONSTS_SVH

// ----------------------------------------------------------------------------
// memory map of the converter and sensor registers
// ----------------------------------------------------------------------------
`define AUX_ADDR_W            12
`define AUX_DATA_W            8
`define AUX_OFS_RX_POWER      12'h324
`define AUX_OFS_AUX_POWER     12'h325
`define AUX_OFS_RESULT_UPPER  12'h327
`define AUX_OFS_RESULT_LOWER  12'h328
`define AUX_OFS_INPUT_SELECT  12'h359

// ----------------------------------------------------------------------------
// register values, fields and reset values
// ----------------------------------------------------------------------------
`define AUX_RESET_VALUE       8'h00
`define AUX_RX_POWER_ADC_ON   8'h10
`define AUX_RX_ADC_ON_BIT     4
`define AUX_AUX_POWER_TEMP_ON 8'h02
`define AUX_AUX_TEMP_ON_BIT   1
`define AUX_SELECT_TEMP       8'h08
`define AUX_SELECT_EXTERNAL   8'h04
`define AUX_LOWER_BITS        2
`define AUX_UPPER_BITS        6

// ----------------------------------------------------------------------------
// timing: conversion time in ns, clock period in ns, derived cycle counts
// ----------------------------------------------------------------------------
`define AUX_CONV_TIME_NS      1000
`define AUX_CLK_PERIOD_NS     40
`define AUX_CONV_CYCLES       ((`AUX_CONV_TIME_NS + `AUX_CLK_PERIOD_NS - 1) / `AUX_CLK_PERIOD_NS)
`define AUX_HOST_MARGIN       2
`define AUX_CNT_W             8

// ----------------------------------------------------------------------------
// temperature scaling: 0.9474 as a q10 fraction, results in q8 degrees
// ----------------------------------------------------------------------------
`define AUX_TEMP_COEF_Q10     11'd970
`define AUX_TEMP_FRAC_BITS    8

`endif

// file: design/aux_pkg.sv
// types shared by the converter device end and the host end
`include "aux_consts.svh"

package aux_pkg;

    // ------------------------------------------------------------------------
    // radio states reported by the radio controller
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        aux_radio_off_state  = 2'h0,
        aux_radio_idle_state = 2'h1,
        aux_receive_state    = 2'h3,
        aux_transmit_state   = 2'h2
    } aux_radio_state_type;

    // ------------------------------------------------------------------------
    // device readback sequencer, gray coded
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        aux_rb_idle    = 2'h0,
        aux_rb_convert = 2'h1,
        aux_rb_low     = 2'h3,
        aux_rb_high    = 2'h2
    } aux_readback_state_type;

    // ------------------------------------------------------------------------
    // host sequencer, gray coded along the full temperature path
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        aux_host_idle    = 4'h0,
        aux_host_rxpwr   = 4'h1,
        aux_host_auxpwr  = 4'h3,
        aux_host_select  = 4'h2,
        aux_host_init    = 4'h6,
        aux_host_wait    = 4'h7,
        aux_host_rdlow   = 4'h5,
        aux_host_rdhigh  = 4'h4,
        aux_host_gotlow  = 4'hc,
        aux_host_gothigh = 4'hd
    } aux_host_state_type;

    // ------------------------------------------------------------------------
    // register state of each module
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic                  busy;
        logic [`AUX_CNT_W-1:0] cnt;
        logic [7:0]            level;
        logic [7:0]            mask;
        logic [7:0]            result;
    } aux_sar_reg_type;

    typedef struct packed {
        logic [7:0]             rx_power;
        logic [7:0]             aux_power;
        logic [7:0]             input_select;
        aux_readback_state_type rb;
        logic [7:0]             result;
        logic [7:0]             rdata;
        logic [2:0][7:0]        level_s1;
        logic [2:0][7:0]        level_s2;
    } aux_device_reg_type;

    typedef struct packed {
        aux_host_state_type state;
        logic [11:0]        addr;
        logic [7:0]         wdata;
        logic               wr;
        logic               rd;
        logic [7:0]         cnt;
        logic               temp_mode;
        logic               cal_mode;
        logic [1:0]         low;
        logic [7:0]         sample;
        logic               sample_valid;
        logic [7:0]         cal_reading;
        logic [7:0]         cal_temp;
        logic [15:0]        temperature;
    } aux_host_reg_type;

endpackage

// file: design/aux_mem_if.sv
// memory access port between host and converter device
`timescale 1ns/10ps
`include "aux_consts.svh"

interface aux_mem_if;
    logic [`AUX_ADDR_W-1:0] addr;
    logic [`AUX_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
    logic [`AUX_DATA_W-1:0] rdata;

    // the device answers reads, the host issues every access
    modport device (input addr, input wdata, input wr, input rd, output rdata);
    modport host   (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// file: design/aux_sar.sv
// successive-approximation converter core with a fixed conversion time
`timescale 1ns/10ps
`include "aux_consts.svh"

module aux_sar
    import aux_pkg::*;
#(
    parameter int CONV_CYCLES = `AUX_CONV_CYCLES
)(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       start,
    input  wire logic [7:0] level,
    output logic            busy,
    output logic            done,
    output logic [7:0]      result
);

    aux_sar_reg_type q;
    aux_sar_reg_type next_q;

    // ------------------------------------------------------------------------
    // one trial bit per cycle, then idle out the rest of the conversion time
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_q = q;
        if (!q.busy && start)
        begin
            next_q.busy   = 1'b1;
            next_q.cnt    = `AUX_CNT_W'(CONV_CYCLES - 1);
            next_q.level  = level;                 // sample and hold
            next_q.mask   = 8'h80;
            next_q.result = 8'h00;
        end
        else if (q.busy)
        begin
            if (q.mask != 8'h00 && q.level >= (q.result | q.mask))
                next_q.result = q.result | q.mask;
            next_q.mask = q.mask >> 1;
            if (q.cnt == '0)
                next_q.busy = 1'b0;
            else
                next_q.cnt = q.cnt - `AUX_CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            q <= '0;
        else
            q <= next_q;
    end

    assign busy   = q.busy;
    assign done   = q.busy && (q.cnt == '0);   // ends the full conversion time
    assign result = q.result;

endmodule

// file: design/aux_device.sv
// converter readback and temperature sensor enable, device end
`timescale 1ns/10ps
`include "aux_consts.svh"

// Function
// [R1] converter digitises temperature, signal strength, external input
// [R2] conversion finishes within about one microsecond
// [R3] sample is 8-bit unsigned, split over two registers
// [R4] input-select register chooses the converter source
// [R5] receive state forces signal strength, powers converter
// [R6] host powers converter outside receive before sampling
// [R7] read upper, read lower bits 1:0, read upper 7:2
// [R8] host enables converter, sensor, then selects sensor
// [R9] auxiliary power write 0x02 powers the temperature sensor
// [R10] input-select write 0x08 routes sensor to converter
// [R11] host scales reading difference by 0.9474 plus reference
// [R12] host stores one reading at known reference temperature
// [R13] all registers reached by host memory accesses
// [R14] writes take effect before next readback, hold
module aux_device
    import aux_pkg::*;
#(
    parameter int CONV_CYCLES = `AUX_CONV_CYCLES
)(
    input  wire logic          clk,
    input  wire logic          resetn,
    aux_mem_if.device          mem,
    input  aux_radio_state_type radio_state,
    input  wire logic [7:0]    temperature_level,
    input  wire logic [7:0]    signal_strength_level,
    input  wire logic [7:0]    external_level,
    output logic               converter_powered,
    output logic               sensor_powered,
    output logic               converter_busy
);

    // ------------------------------------------------------------------------
    // source indices into the synchronised analog levels
    // ------------------------------------------------------------------------
    localparam logic [1:0] SRC_TEMP     = 2'h0;
    localparam logic [1:0] SRC_STRENGTH = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;

    // state and internal nets
    aux_device_reg_type q;
    aux_device_reg_type next_q;

    logic       in_receive;
    logic [1:0] source;
    logic [7:0] source_level;
    logic       start;
    logic       conv_done;
    logic [7:0] conv_result;

    // ------------------------------------------------------------------------
    // source decode: receive overrides the host selection
    // ------------------------------------------------------------------------
    function automatic logic [1:0] aux_source(input logic [7:0] select,
                                              input logic       receive);
        if (receive)
            return SRC_STRENGTH;                   // [R5]
        else if (select == `AUX_SELECT_TEMP)
            return SRC_TEMP;                       // [R10]
        else if (select == `AUX_SELECT_EXTERNAL)
            return SRC_EXTERNAL;
        // other codes: signal strength
        else
            return SRC_STRENGTH;
    endfunction

    // ------------------------------------------------------------------------
    // power and routing
    // ------------------------------------------------------------------------
    assign in_receive = (radio_state == aux_receive_state);
    assign source     = aux_source(q.input_select, in_receive); // [R4]
    // converter runs in receive or when the host powered it up
    assign converter_powered = in_receive
                             || q.rx_power[`AUX_RX_ADC_ON_BIT];   // [R5]
    // sensor power: plain register bit
    assign sensor_powered    = q.aux_power[`AUX_AUX_TEMP_ON_BIT]; // [R9]

    // an unpowered sensor presents zero rather than a stale level
    // late sensor power-up reads cold
    always_comb
    begin
        unique case (source)
            SRC_TEMP:     source_level = sensor_powered ? q.level_s2[SRC_TEMP] : 8'h00;
            SRC_EXTERNAL: source_level = q.level_s2[SRC_EXTERNAL];
            default:      source_level = q.level_s2[SRC_STRENGTH];
        endcase
    end

    // ------------------------------------------------------------------------
    // a read of the upper register starts a sequence unless the final upper read is due
    // ------------------------------------------------------------------------
    // start is dropped while busy, so an
    // early upper read cannot cut a run short
    assign start = mem.rd && (mem.addr == `AUX_OFS_RESULT_UPPER)
                 && (q.rb != aux_rb_high) && converter_powered;     // [R7]

    aux_sar #(
        .CONV_CYCLES (CONV_CYCLES)
    ) aux_sar_i (
        .clk    (clk),
        .resetn (resetn),
        .start  (start),
        .level  (source_level),
        .busy   (converter_busy),
        .done   (conv_done),
        .result (conv_result)
    );

    // ------------------------------------------------------------------------
    // register file, readback sequencer and level synchronisers
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_q = q;
        // analog levels are asynchronous; two stages before any use  [R1]
        // slow levels: tearing is rare
        next_q.level_s1[SRC_TEMP]     = temperature_level;
        next_q.level_s1[SRC_STRENGTH] = signal_strength_level;
        next_q.level_s1[SRC_EXTERNAL] = external_level;
        next_q.level_s2               = q.level_s1;
        next_q.rdata                  = 8'h00;          // unmapped reads as zero

        // conversion finished: hold the sample for the two result reads
        // sample held until the next run ends or an unpowered upper read zeroes it
        if (conv_done && q.rb == aux_rb_convert)
        begin
            next_q.result = conv_result;                // [R2]
            next_q.rb     = aux_rb_low;
        end

        // writes land at once, so the next sequence already sees them
        if (mem.wr)                                     // [R13]
        begin
            unique case (mem.addr)
                `AUX_OFS_RX_POWER:     next_q.rx_power     = mem.wdata; // [R14]
                `AUX_OFS_AUX_POWER:    next_q.aux_power    = mem.wdata; // [R9]
                `AUX_OFS_INPUT_SELECT: next_q.input_select = mem.wdata; // [R4]
                // result registers: read only
                default:               next_q.rx_power     = q.rx_power;
            endcase
        end

        // reads answer one cycle later through the rdata register
        if (mem.rd)                                     // [R13]
        begin
            unique case (mem.addr)
                `AUX_OFS_RX_POWER:     next_q.rdata = q.rx_power;
                `AUX_OFS_AUX_POWER:    next_q.rdata = q.aux_power;
                `AUX_OFS_INPUT_SELECT: next_q.rdata = q.input_select;
                `AUX_OFS_RESULT_LOWER:
                begin
                    // low bits; an early read returns the previous sample
                    next_q.rdata = {6'h00, q.result[`AUX_LOWER_BITS-1:0]}; // [R3]
                    if (q.rb == aux_rb_low)
                        next_q.rb = aux_rb_high;
                end
                `AUX_OFS_RESULT_UPPER:
                begin
                    next_q.rdata = {2'h0, q.result[7:`AUX_LOWER_BITS]};    // [R3]
                    if (q.rb == aux_rb_high)
                        next_q.rb = aux_rb_idle;        // [R7]
                    else if (converter_powered)
                        next_q.rb = aux_rb_convert;     // [R7]
                    else
                    begin
                        // nothing to convert: the sequence yields zero
                        next_q.result = 8'h00;
                        next_q.rb     = aux_rb_low;
                    end
                end
                // unmapped: reads as zero
                default:               next_q.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // state register; written settings hold until rewritten or reset
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            // settings to reset values
            q              <= '0;
            q.rx_power     <= `AUX_RESET_VALUE;
            q.aux_power    <= `AUX_RESET_VALUE;
            q.input_select <= `AUX_RESET_VALUE;
            q.rb           <= aux_rb_idle;
        end
        else
        begin
            q <= next_q;                                // [R14]
        end
    end

    // ------------------------------------------------------------------------
    // bus answer straight from the register
    // ------------------------------------------------------------------------
    // rdata stands one cycle after rd
    assign mem.rdata = q.rdata;

endmodule

// file: design/aux_host.sv
// host end: enable sequence, three-read readback and temperature scaling
`timescale 1ns/10ps
`include "aux_consts.svh"

module aux_host
    import aux_pkg::*;
#(
    parameter int WAIT_CYCLES = `AUX_CONV_CYCLES + `AUX_HOST_MARGIN
)(
    input  wire logic           clk,
    input  wire logic           resetn,
    aux_mem_if.host             mem,
    input  aux_radio_state_type radio_state,
    input  wire logic           sample_req,
    input  wire logic           temp_req,
    input  wire logic           cal_req,
    input  wire logic [7:0]     cal_temperature,
    output logic                busy,
    output logic [7:0]          sample,
    output logic                sample_valid,
    output logic [7:0]          calibration_reading,
    output logic [15:0]         temperature
);

    aux_host_reg_type q;
    aux_host_reg_type next_q;
    logic [7:0]       new_sample;

    // ------------------------------------------------------------------------
    // q8 degrees: coefficient times reading difference plus reference
    // ------------------------------------------------------------------------
    function automatic logic [15:0] aux_temperature(input logic [7:0] reading,
                                                    input logic [7:0] cal,
                                                    input logic [7:0] t_cal);
        logic signed [8:0]  diff;
        logic signed [19:0] prod;
        logic signed [17:0] sum;
        diff = $signed({1'b0, reading}) - $signed({1'b0, cal});
        prod = diff * $signed({1'b0, `AUX_TEMP_COEF_Q10});
        sum  = 18'(prod >>> 2) + 18'($signed({t_cal, 8'h00}));
        return sum[15:0];                               // [R11]
    endfunction

    assign new_sample = {mem.rdata[`AUX_UPPER_BITS-1:0], q.low};

    // ------------------------------------------------------------------------
    // sequencer; strobes are registered and last one cycle each
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_q              = q;
        next_q.wr           = 1'b0;
        next_q.rd           = 1'b0;
        next_q.sample_valid = 1'b0;
        unique case (q.state)
            aux_host_idle:
            begin
                if (temp_req || cal_req)
                begin
                    next_q.temp_mode = 1'b1;
                    next_q.cal_mode  = cal_req;
                    if (cal_req)
                        next_q.cal_temp = cal_temperature;
                    next_q.state = aux_host_rxpwr;      // [R8]
                end
                else if (sample_req)
                begin
                    next_q.temp_mode = 1'b0;
                    next_q.cal_mode  = 1'b0;
                    // receive powers the converter by itself
                    next_q.state = (radio_state == aux_receive_state)
                                 ? aux_host_init : aux_host_rxpwr;
                end
            end
            aux_host_rxpwr:
            begin
                next_q.wr    = 1'b1;                    // [R6]
                next_q.addr  = `AUX_OFS_RX_POWER;       // [R13]
                next_q.wdata = `AUX_RX_POWER_ADC_ON;
                next_q.state = q.temp_mode ? aux_host_auxpwr : aux_host_init;
            end
            aux_host_auxpwr:
            begin
                next_q.wr    = 1'b1;                    // [R9]
                next_q.addr  = `AUX_OFS_AUX_POWER;
                next_q.wdata = `AUX_AUX_POWER_TEMP_ON;
                next_q.state = aux_host_select;
            end
            aux_host_select:
            begin
                next_q.wr    = 1'b1;                    // [R10]
                next_q.addr  = `AUX_OFS_INPUT_SELECT;
                next_q.wdata = `AUX_SELECT_TEMP;
                next_q.state = aux_host_init;
            end
            aux_host_init:
            begin
                next_q.rd    = 1'b1;                    // [R7]
                next_q.addr  = `AUX_OFS_RESULT_UPPER;
                next_q.cnt   = 8'(WAIT_CYCLES);
                next_q.state = aux_host_wait;
            end
            aux_host_wait:
            begin
                // margin over the conversion time so the sample is fresh
                if (q.cnt == 8'h00)
                    next_q.state = aux_host_rdlow;
                else
                    next_q.cnt = q.cnt - 8'h01;
            end
            aux_host_rdlow:
            begin
                next_q.rd    = 1'b1;                    // [R7]
                next_q.addr  = `AUX_OFS_RESULT_LOWER;
                next_q.state = aux_host_rdhigh;
            end
            aux_host_rdhigh:
            begin
                next_q.rd    = 1'b1;                    // [R7]
                next_q.addr  = `AUX_OFS_RESULT_UPPER;
                next_q.state = aux_host_gotlow;
            end
            aux_host_gotlow:
            begin
                next_q.low   = mem.rdata[`AUX_LOWER_BITS-1:0];
                next_q.state = aux_host_gothigh;
            end
            aux_host_gothigh:
            begin
                next_q.sample       = new_sample;
                next_q.sample_valid = 1'b1;
                if (q.cal_mode)
                    next_q.cal_reading = new_sample;    // [R12]
                if (q.temp_mode)
                    next_q.temperature = aux_temperature(new_sample,
                        q.cal_mode ? new_sample : q.cal_reading, q.cal_temp);
                next_q.state = aux_host_idle;
            end
            default:
                next_q.state = aux_host_idle;
        endcase
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q       <= '0;
            q.state <= aux_host_idle;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign mem.addr            = q.addr;
    assign mem.wdata           = q.wdata;
    assign mem.wr              = q.wr;
    assign mem.rd              = q.rd;
    assign busy                = (q.state != aux_host_idle);
    assign sample              = q.sample;
    assign sample_valid        = q.sample_valid;
    assign calibration_reading = q.cal_reading;
    assign temperature         = q.temperature;

endmodule

// file: test/aux_readback_asserts.sv
// interface checks on the converter readback memory port
`timescale 1ns/10ps
module aux_readback_asserts (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [11:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_one_strobe: assert property (!(wr && rd)) else $error("wr with rd");
    a_rdata_idle: assert property (!rd |=> rdata == 8'h00) else $error("rdata idle");
    a_low_field: assert property (rd && addr == 12'h328 |=> rdata[7:2] == 6'h00)
        else $error("lower field");
    a_up_field: assert property (rd && addr == 12'h327 |=> rdata[7:6] == 2'h0)
        else $error("upper field");
    a_low_then_high: assert property (rd && addr == 12'h328 |=> rd && addr == 12'h327)
        else $error("read order");
    // a fresh start read is followed by eight cycles without a read
    a_conv_wait: assert property (rd && addr == 12'h327 && !$past(rd) |=> !rd [*8])
        else $error("early read");
    a_sensor_order: assert property (wr && addr == 12'h325 |-> wdata == 8'h02 &&
        $past(wr) && $past(addr) == 12'h324) else $error("sensor enable");
    a_select_order: assert property (wr && addr == 12'h359 |-> wdata == 8'h08 &&
        $past(addr) == 12'h325) else $error("select");
    cover property (wr && addr == 12'h324);
    cover property (wr && addr == 12'h359);
    cover property (rd && addr == 12'h328);
endmodule

// file: test/aux_adc_temperature_readback_tb_top.sv
// bench joining host and device ends over the memory port
`timescale 1ns/10ps
`include "aux_consts.svh"
module aux_adc_temperature_readback_tb_top;
    import aux_pkg::*;
    logic                clk = 1'b0;
    logic                resetn = 1'b0;
    aux_radio_state_type radio_state = aux_radio_off_state;
    logic [7:0]          t_lvl = 8'h5a, s_lvl = 8'h9d, cal_t = 8'h19;
    logic                s_req = 1'b0, t_req = 1'b0, c_req = 1'b0;
    logic                cpow, spow, valid, h_busy, c_busy;
    logic [7:0]          sample, cal;
    logic [15:0]         temperature;
    int                  num_errors = 0, cmp_count = 0;
    always #20 clk = ~clk;
    aux_mem_if aux_mem_if_i ();
    aux_device aux_device_i (.clk, .resetn, .mem(aux_mem_if_i.device), .radio_state,
        .temperature_level(t_lvl), .signal_strength_level(s_lvl), .external_level(8'h33),
        .converter_powered(cpow), .sensor_powered(spow), .converter_busy(c_busy));
    aux_host aux_host_i (.clk, .resetn, .mem(aux_mem_if_i.host), .radio_state,
        .sample_req(s_req), .temp_req(t_req), .cal_req(c_req), .cal_temperature(cal_t),
        .busy(h_busy), .sample, .sample_valid(valid), .calibration_reading(cal), .temperature);
    aux_readback_asserts aux_readback_asserts_i (.clk, .resetn, .addr(aux_mem_if_i.addr),
        .wdata(aux_mem_if_i.wdata), .wr(aux_mem_if_i.wr), .rd(aux_mem_if_i.rd),
        .rdata(aux_mem_if_i.rdata));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one request pulse, then a bounded wait for the sample strobe
    task automatic run(input int which);
        int n;
        int nb;
        nb = 0;
        @(posedge clk);
        s_req <= (which == 0);
        t_req <= (which == 1);
        c_req <= (which == 2);
        @(posedge clk);
        {s_req, t_req, c_req} <= 3'h0;
        for (n = 0; n < 200 && valid !== 1'b1; n++)
        begin
            @(posedge clk) #1;
            nb += c_busy;
        end
        if (n == 200)
        begin
            num_errors++;
            complete_run();
        end
        chk({h_busy, c_busy, 6'h0, 8'(nb)}, 16'(`AUX_CONV_CYCLES));
    endtask
    // radio off, select still at reset so signal strength is converted
    task automatic t_plain();
        run(0);
        chk({8'h0, sample}, 16'h9d);
        chk({14'h0, cpow, spow}, 16'h2);
        $display("plain done");
    endtask
    task automatic t_temp();
        radio_state <= aux_radio_idle_state;
        run(1);
        chk({8'h0, sample}, 16'h5a);
        chk({14'h0, cpow, spow}, 16'h3);
        $display("temp done");
    endtask
    // reference reading first, then a reading 16 counts warmer
    task automatic t_cal();
        radio_state <= aux_transmit_state;
        run(2);
        chk({8'h0, cal}, 16'h5a);
        chk(temperature, 16'h1900);
        t_lvl <= 8'h6a;
        run(1);
        chk(temperature, 16'h2828);
        $display("cal done");
    endtask
    // receive overrides the held temperature selection
    task automatic t_rx();
        radio_state <= aux_receive_state;
        s_lvl <= 8'hc3;
        run(0);
        chk({8'h0, sample}, 16'hc3);
        chk({14'h0, cpow, spow}, 16'h3);
        $display("receive done");
    endtask
    // reset with the host idle, then a receive sample
    task automatic t_reset();
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk) #1;
        chk({sample, cal}, 16'h0);
        chk({14'h0, cpow, spow}, 16'h2);
        @(posedge clk);
        resetn <= 1'b1;
        run(0);
        chk({8'h0, sample}, 16'hc3);
        $display("reset done");
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_plain();
        t_temp();
        t_cal();
        t_rx();
        t_reset();
        complete_run();
    end
endmodule
